// File: tcr_cfg.svh
// Purpose: constants for the timer count, reload and capture block
// Assumes: byte registers on a word-wide APB port
// Notes: printed offsets are not all multiples of four, so byte address = 4 * index
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define TCR_IDX_COUNT_LOW 8'h68
`define TCR_IDX_COUNT_HIGH 8'h69
`define TCR_IDX_CAP_CTL 8'h6A
`define TCR_IDX_CAPA_LOW 8'h6B
`define TCR_IDX_CAPA_HIGH 8'h6C
`define TCR_IDX_CAPB_LOW 8'h6D
`define TCR_IDX_CAPB_HIGH 8'h6E
`define TCR_IDX_TIMER_CTL 8'h70

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TCR_CTL_ENABLE 0
`define TCR_CTL_CONTINUOUS 1
`define TCR_CTL_FORCE_RELOAD 2
`define TCR_EDGE_SELECT_CHAN_A_LSB 0
`define TCR_EDGE_SELECT_CHAN_B_LSB 2
`define TCR_CAP_CTL_MASK 8'h0F
`define TCR_CTL_MASK 8'h03
`define TCR_RESET_BYTE 8'h00
`define TCR_RESET_WORD 16'h0000

`endif

// File: tcr_pkg.sv
// Purpose: types for the timer count, reload and capture block
// Assumes: tcr_cfg.svh holds the numbers
// Notes: edge coding is shared by both capture channels
package tcr_pkg;

	typedef enum logic [1:0] {
		TCR_EDGE_OFF = 2'h0,
		TCR_EDGE_FALL = 2'h1,
		TCR_EDGE_RISE = 2'h2,
		TCR_EDGE_BOTH = 2'h3
	} tcr_edge_t;

	typedef enum logic {
		TCR_APB_IDLE,
		TCR_APB_DONE
	} tcr_apb_state_t;

endpackage

// File: tcr_capture_chan.sv
// Purpose: one capture channel: synchroniser, edge detector and value register
// Assumes: pin is asynchronous to clk
// Notes: capture lands three edges after the pin moves
`include "tcr_cfg.svh"
module tcr_capture_chan
	import tcr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin,
	input wire logic [1:0] edge_sel,
	input wire logic [WIDTH-1:0] count,
	output logic [WIDTH-1:0] value_q,
	output logic event_q
);

	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic hit;

	// ----------------------------------------
	// Synchroniser and edge detection
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= pin; // see (R14)
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	always_comb begin
		unique case (tcr_edge_t'(edge_sel))
			TCR_EDGE_OFF: hit = 1'b0; // see (R10) see (R11)
			TCR_EDGE_FALL: hit = prev_q && !sync2_q;
			TCR_EDGE_RISE: hit = !prev_q && sync2_q;
			TCR_EDGE_BOTH: hit = prev_q != sync2_q;
		endcase
	end

	// ----------------------------------------
	// Capture value
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			value_q <= '0;
			event_q <= 1'b0;
		end else begin
			event_q <= hit;
			if (hit) begin
				value_q <= count; // see (R13)
			end
		end
	end

endmodule // tcr_capture_chan

// File: tcr_timer.sv
// Function
// (R01) A high-byte read returns the counter's upper byte as held at the last low-byte read.
// (R02) Every low-byte read copies the counter's upper byte into a holding register.
// (R03) Reading the count bytes never disturbs counting or reloading.
// (R04) Software reads the low byte first and the high byte second for a coherent count.
// (R05) The high byte carries counter bit 15 at bit 7 down to counter bit 8 at bit 0.
// (R06) Each count byte and reload byte share one address: reads give count, writes set reload.
// (R07) In continuous mode the reload value enters the counter when the count ends.
// (R08) Writing 1 to the force-reload bit loads the reload value on the next clock edge.
// (R09) The reload value is high byte over low byte; both are write-only and reset to zero.
// (R10) Channel B edge field bits 3:2 selects off, falling, rising or both edges.
// (R11) Channel A edge field bits 1:0 uses the same coding.
// (R12) Channel A serves the first capture pin of this timer and channel B the second.
// (R13) A selected edge stores the current count in that channel's capture register.
// (R14) Capture inputs are synchronised and edges found by comparing successive samples.
//
// Purpose: 16-bit down counter with reload, coherent readout and two capture channels on APB
// Assumes: 32-bit APB, byte registers in the low lanes, byte address = 4 * index
// Notes: counts down from reload to 1; end of count is the step from 1 to reload or 0
//
// Implementation choice: the APB interface to the registers.
`include "tcr_cfg.svh"
module tcr_timer
	import tcr_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_chan_a,
	input wire logic capture_input_chan_b,
	output logic [WIDTH-1:0] count_q,
	output logic end_of_count_q,
	output logic capture_event_a_q,
	output logic capture_event_b_q
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	tcr_apb_state_t apb_state_q;
	logic [7:0] reload_value_low_q;
	logic [7:0] reload_value_high_q;
	logic [7:0] count_snapshot_high_q;
	logic [7:0] capture_edge_control_q;
	logic [7:0] timer_control_q;
	logic force_reload_q;
	logic [WIDTH-1:0] cap_a_value;
	logic [WIDTH-1:0] cap_b_value;
	logic cap_a_event;
	logic cap_b_event;
	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [ADDR_W-3:0] idx;
	logic [7:0] rd_byte;
	logic [WIDTH-1:0] reload_word;
	logic count_end;

	function automatic logic hit_idx(input logic [ADDR_W-3:0] a, input logic [7:0] ref_idx);
		hit_idx = a == (ADDR_W-2)'(ref_idx);
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign idx = paddr[ADDR_W-1:2];
	assign access = psel && penable && (apb_state_q == TCR_APB_IDLE);
	assign wr_en = access && pwrite && pstrb[0] && mapped;
	assign rd_en = access && !pwrite && mapped;

	always_comb begin
		mapped = hit_idx(idx, `TCR_IDX_COUNT_LOW) || hit_idx(idx, `TCR_IDX_COUNT_HIGH)
			|| hit_idx(idx, `TCR_IDX_CAP_CTL) || hit_idx(idx, `TCR_IDX_CAPA_LOW)
			|| hit_idx(idx, `TCR_IDX_CAPA_HIGH) || hit_idx(idx, `TCR_IDX_CAPB_LOW)
			|| hit_idx(idx, `TCR_IDX_CAPB_HIGH) || hit_idx(idx, `TCR_IDX_TIMER_CTL);
	end

	always_comb begin
		rd_byte = `TCR_RESET_BYTE;
		if (hit_idx(idx, `TCR_IDX_COUNT_LOW)) begin
			rd_byte = count_q[7:0]; // see (R06)
		end else if (hit_idx(idx, `TCR_IDX_COUNT_HIGH)) begin
			rd_byte = count_snapshot_high_q; // see (R01) see (R06)
		end else if (hit_idx(idx, `TCR_IDX_CAP_CTL)) begin
			rd_byte = capture_edge_control_q & `TCR_CAP_CTL_MASK;
		end else if (hit_idx(idx, `TCR_IDX_CAPA_LOW)) begin
			rd_byte = cap_a_value[7:0];
		end else if (hit_idx(idx, `TCR_IDX_CAPA_HIGH)) begin
			rd_byte = cap_a_value[15:8];
		end else if (hit_idx(idx, `TCR_IDX_CAPB_LOW)) begin
			rd_byte = cap_b_value[7:0];
		end else if (hit_idx(idx, `TCR_IDX_CAPB_HIGH)) begin
			rd_byte = cap_b_value[15:8];
		end else if (hit_idx(idx, `TCR_IDX_TIMER_CTL)) begin
			rd_byte = timer_control_q & `TCR_CTL_MASK;
		end
	end

	// One wait state: answer registered, so every output comes from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			apb_state_q <= TCR_APB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			unique case (apb_state_q)
				TCR_APB_IDLE: begin
					pready <= access;
					pslverr <= access && !mapped;
					if (access) begin
						apb_state_q <= TCR_APB_DONE;
						prdata <= (rd_en) ? {24'h000000, rd_byte} : 32'h00000000;
					end
				end
				TCR_APB_DONE: begin
					apb_state_q <= TCR_APB_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reload_value_low_q <= `TCR_RESET_BYTE; // see (R09)
			reload_value_high_q <= `TCR_RESET_BYTE;
			capture_edge_control_q <= `TCR_RESET_BYTE;
			timer_control_q <= `TCR_RESET_BYTE;
			force_reload_q <= 1'b0;
		end else begin
			force_reload_q <= 1'b0;
			if (wr_en) begin
				if (hit_idx(idx, `TCR_IDX_COUNT_LOW)) begin
					reload_value_low_q <= pwdata[7:0]; // see (R06)
				end
				if (hit_idx(idx, `TCR_IDX_COUNT_HIGH)) begin
					reload_value_high_q <= pwdata[7:0]; // see (R06)
				end
				if (hit_idx(idx, `TCR_IDX_CAP_CTL)) begin
					capture_edge_control_q <= pwdata[7:0] & `TCR_CAP_CTL_MASK;
				end
				if (hit_idx(idx, `TCR_IDX_TIMER_CTL)) begin
					timer_control_q <= pwdata[7:0] & `TCR_CTL_MASK;
					force_reload_q <= pwdata[`TCR_CTL_FORCE_RELOAD]; // see (R08)
				end
			end
		end
	end

	// ----------------------------------------
	// Count snapshot
	// ----------------------------------------
	// Only a low-byte read moves the snapshot; high-byte read has no side effect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_snapshot_high_q <= `TCR_RESET_BYTE;
		end else if (rd_en && hit_idx(idx, `TCR_IDX_COUNT_LOW)) begin
			count_snapshot_high_q <= count_q[15:8]; // see (R02) see (R05) see (R04)
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	assign reload_word = {reload_value_high_q, reload_value_low_q}; // see (R09)
	assign count_end = timer_control_q[`TCR_CTL_ENABLE] && (count_q == WIDTH'(1));

	// Reads feed nothing here, so they cannot disturb counting
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_q <= `TCR_RESET_WORD;
			end_of_count_q <= 1'b0;
		end else begin
			end_of_count_q <= count_end;
			if (force_reload_q) begin
				count_q <= reload_word; // see (R08) see (R03)
			end else if (count_end) begin
				if (timer_control_q[`TCR_CTL_CONTINUOUS]) begin
					count_q <= reload_word; // see (R07)
				end else begin
					count_q <= `TCR_RESET_WORD;
				end
			end else if (timer_control_q[`TCR_CTL_ENABLE] && count_q != `TCR_RESET_WORD) begin
				count_q <= count_q - WIDTH'(1);
			end
		end
	end

	// ----------------------------------------
	// Capture channels
	// ----------------------------------------
	tcr_capture_chan #(
		.WIDTH(WIDTH)
	) u_chan_a (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(capture_input_chan_a), // see (R12)
		.edge_sel(capture_edge_control_q[`TCR_EDGE_SELECT_CHAN_A_LSB +: 2]), // see (R11)
		.count(count_q),
		.value_q(cap_a_value),
		.event_q(cap_a_event)
	);

	tcr_capture_chan #(
		.WIDTH(WIDTH)
	) u_chan_b (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(capture_input_chan_b), // see (R12)
		.edge_sel(capture_edge_control_q[`TCR_EDGE_SELECT_CHAN_B_LSB +: 2]), // see (R10)
		.count(count_q),
		.value_q(cap_b_value),
		.event_q(cap_b_event)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			capture_event_a_q <= 1'b0;
			capture_event_b_q <= 1'b0;
		end else begin
			capture_event_a_q <= cap_a_event;
			capture_event_b_q <= cap_b_event;
		end
	end

endmodule // tcr_timer

// File: tcr_timer_properties.sv
// Purpose: port properties of tcr_timer
// Assumes: one APB wait state, byte address = 4 * index
// Notes: capture delay is checked as a window
`include "tcr_cfg.svh"
module tcr_timer_checker
	import tcr_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic capture_input_chan_a,
	input wire logic capture_input_chan_b,
	input wire logic [WIDTH-1:0] count_q,
	input wire logic end_of_count_q,
	input wire logic capture_event_a_q,
	input wire logic capture_event_b_q
);
	logic [6:0] hist_a_q;
	logic [6:0] hist_b_q;
	logic mapped;
	assign mapped = paddr[ADDR_W-1:2] inside {[`TCR_IDX_COUNT_LOW:`TCR_IDX_CAPB_HIGH], `TCR_IDX_TIMER_CTL};
	// Pin history, so a capture can be traced to a real change
	always_ff @(posedge clk) begin
		hist_a_q <= {hist_a_q[5:0], capture_input_chan_a};
		hist_b_q <= {hist_b_q[5:0], capture_input_chan_b};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_wait_state;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait_state: assert property (p_wait_state) else $error("no answer");
	property p_err_decode;
		psel && penable && !pready |=> pslverr == !$past(mapped);
	endproperty
	a_err_decode: assert property (p_err_decode) else $error("bad decode");
	property p_ready_pulse;
		pready |=> !pready && !pslverr;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
	property p_read_hold;
		!$stable(prdata) |-> pready;
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("data moved");
	property p_byte_lane;
		prdata[31:8] == 24'h000000;
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("upper lanes");
	property p_eoc_cause;
		end_of_count_q |-> $past(count_q) == WIDTH'(1);
	endproperty
	a_eoc_cause: assert property (p_eoc_cause) else $error("stray end");
	property p_cap_a;
		capture_event_a_q |-> hist_a_q[6:1] != 6'h00 && hist_a_q[6:1] != 6'h3F;
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("stray capture a");
	property p_cap_b;
		capture_event_b_q |-> hist_b_q[6:1] != 6'h00 && hist_b_q[6:1] != 6'h3F;
	endproperty
	a_cap_b: assert property (p_cap_b) else $error("stray capture b");
endmodule // tcr_timer_checker

bind tcr_timer tcr_timer_checker #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) tcr_timer_checker_inst (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .count_q(count_q),
	.capture_input_chan_a(capture_input_chan_a), .capture_input_chan_b(capture_input_chan_b),
	.end_of_count_q(end_of_count_q), .capture_event_a_q(capture_event_a_q),
	.capture_event_b_q(capture_event_b_q)
);

// File: test_tcr_timer.sv
// Purpose: self-checking bench for tcr_timer
// Assumes: reads are scored by a monitor from a queue
// Notes: live count reads check only certain bits
`include "tcr_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("Error %0t got %0h exp %0h", $time, (g), (e)); end end
module test_tcr_timer
	import tcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, end_of_count_q, capture_event_a_q, capture_event_b_q;
	logic capture_input_chan_a = 1'b0;
	logic capture_input_chan_b = 1'b0;
	logic [15:0] count_q, r1, r2;
	logic [64:0] exp_q[$];
	logic [64:0] note;
	logic [31:0] wd;
	int err_count = 0, compares = 0, ev_a = 0, ev_b = 0, eocs = 0, a0, b0;
	always #25 clk = ~clk;
	tcr_timer tcr_timer_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_input_chan_a(capture_input_chan_a),
		.capture_input_chan_b(capture_input_chan_b), .count_q(count_q), .end_of_count_q(end_of_count_q),
		.capture_event_a_q(capture_event_a_q), .capture_event_b_q(capture_event_b_q));
	task automatic conclude;
		$display("Mismatches %0d, compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Note {error, value, mask}, then hold the request until ready
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
		input logic [31:0] e, input logic [31:0] m, input logic er);
		int n;
		n = 0;
		exp_q.push_back({er, e, m});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d, 4'hF, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, idx, 32'h0, 4'h0, e, m, 1'b0);
	endtask
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			note = exp_q.pop_front();
			`CHK({pslverr, prdata & note[31:0]}, {note[64], note[63:32] & note[31:0]})
		end
	end
	// Negedge counting keeps the tallies clear of the driver's edge
	always @(negedge clk) begin
		if (capture_event_a_q === 1'b1) ev_a++;
		if (capture_event_b_q === 1'b1) ev_b++;
		if (end_of_count_q === 1'b1) eocs++;
	end
	initial begin
		repeat (2000) @(posedge clk);
		err_count++;
		conclude();
	end
	initial begin
		void'($urandom(75));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`TCR_IDX_COUNT_LOW, 32'h0, 32'hFF);
		rd(`TCR_IDX_CAP_CTL, 32'h0, 32'hFF);
		xfer(1'b0, 8'h6F, 32'h0, 4'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
		r1 = 16'($urandom);
		r2 = {~r1[15:8], 8'($urandom)};
		wr(`TCR_IDX_COUNT_LOW, {24'h0, r1[7:0]});
		wr(`TCR_IDX_COUNT_HIGH, {24'h0, r1[15:8]});
		wr(`TCR_IDX_TIMER_CTL, 32'h4);
		wr(`TCR_IDX_COUNT_HIGH, {24'h0, r2[15:8]});
		wr(`TCR_IDX_COUNT_LOW, {24'h0, r2[7:0]});
		rd(`TCR_IDX_COUNT_LOW, {24'h0, r1[7:0]}, 32'hFF);
		wr(`TCR_IDX_TIMER_CTL, 32'h4);
		rd(`TCR_IDX_COUNT_HIGH, {24'h0, r1[15:8]}, 32'hFF);
		rd(`TCR_IDX_COUNT_LOW, {24'h0, r2[7:0]}, 32'hFF);
		rd(`TCR_IDX_COUNT_HIGH, {24'h0, r2[15:8]}, 32'hFF);
		for (int i = 0; i < 4; i++) begin
			a0 = ev_a;
			b0 = ev_b;
			wd = $urandom;
			wr(`TCR_IDX_CAP_CTL, {wd[31:4], 2'(3 - i), 2'(i)});
			rd(`TCR_IDX_CAP_CTL, {28'h0, 2'(3 - i), 2'(i)}, 32'hFF);
			capture_input_chan_a <= 1'b1;
			capture_input_chan_b <= 1'b1;
			repeat (10) @(posedge clk);
			capture_input_chan_a <= 1'b0;
			capture_input_chan_b <= 1'b0;
			repeat (10) @(posedge clk);
			`CHK(ev_a - a0, (i & 1) + (i >> 1))
			`CHK(ev_b - b0, ((3 - i) & 1) + ((3 - i) >> 1))
		end
		`CHK(count_q, r2)
		// New count for channel A only, so the two pins give different values
		wr(`TCR_IDX_COUNT_LOW, {24'h0, ~r2[7:0]});
		wr(`TCR_IDX_TIMER_CTL, 32'h4);
		capture_input_chan_a <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`TCR_IDX_CAPA_LOW, {24'h0, ~r2[7:0]}, 32'hFF);
		rd(`TCR_IDX_CAPA_HIGH, {24'h0, r2[15:8]}, 32'hFF);
		rd(`TCR_IDX_CAPB_LOW, {24'h0, r2[7:0]}, 32'hFF);
		rd(`TCR_IDX_CAPB_HIGH, {24'h0, r2[15:8]}, 32'hFF);
		xfer(1'b1, `TCR_IDX_CAP_CTL, 32'h0F, 4'hE, 32'h0, 32'h0, 1'b0);
		rd(`TCR_IDX_CAP_CTL, 32'h03, 32'hFF);
		wr(`TCR_IDX_COUNT_LOW, 32'h05);
		wr(`TCR_IDX_COUNT_HIGH, 32'h00);
		wr(`TCR_IDX_TIMER_CTL, 32'h7);
		repeat (5) @(posedge clk);
		a0 = eocs;
		// Ten reads of the live count span exactly 40 cycles
		repeat (5) begin
			rd(`TCR_IDX_COUNT_LOW, 32'h0, 32'hF8);
			rd(`TCR_IDX_COUNT_HIGH, 32'h0, 32'hFF);
		end
		`CHK(eocs - a0, 8)
		wr(`TCR_IDX_TIMER_CTL, 32'h5);
		repeat (10) @(posedge clk);
		rd(`TCR_IDX_COUNT_LOW, 32'h0, 32'hFF);
		`CHK(count_q, 16'h0000)
		conclude();
	end
endmodule // test_tcr_timer
